/* pbc_cfg.svh */
/*
  constants of the loop bandwidth/programming control block: register byte
  offsets, field positions, reset values and timing counts.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH

`define PBC_OFS_CONTROL 8'h00
`define PBC_OFS_BANDWIDTH 8'h04
`define PBC_OFS_PROGRAMMING 8'h08
`define PBC_OFS_SYSTEM 8'h0c

// control register bit positions
`define PBC_CTL_IRQ_EN 7
`define PBC_CTL_FLAG 6
`define PBC_CTL_PWR_ON 5
`define PBC_CTL_BCS 4
// bandwidth register bit positions
`define PBC_BW_AUTO 7
`define PBC_BW_LOCK 6
`define PBC_BW_TRACK 5
`define PBC_BW_XLOSS 4
// programming register: multiplier in [7:4], vco range in [3:0]
`define PBC_PG_MUL_HI 7
`define PBC_PG_MUL_LO 4
`define PBC_PG_VRS_HI 3
`define PBC_PG_VRS_LO 0
// system register bit positions
`define PBC_SYS_BREAK_FLAG_CLEAR_ENABLE 0

`define PBC_RST_MUL 4'h6
`define PBC_RST_VRS 4'h6
`define PBC_CTL_UNUSED 4'hf

// crystal loss window: vco cycles per multiplier unit
`define PBC_XLD_CYC_PER_N 4
`define PBC_XLD_CNT_W 6

`endif

/* pbc_pkg.sv */
/*
  types of the loop bandwidth/programming control block.
  assumes pbc_cfg.svh alongside.
*/
`include "pbc_cfg.svh"

package pbc_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pbc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pbc_apb_rsp_t;

  typedef enum logic [2:0] {
    XLD_IDLE = 3'b001,
    XLD_WAIT = 3'b010,
    XLD_DONE = 3'b100
  } pbc_xld_state_t;

  typedef struct packed {
    logic active;
    logic clear;
    logic lost;
  } pbc_xld_io_t;

endpackage

/* pbc_edge_det.sv */
/*
  edge detector for the sampled lock indicator; flags any change.
  assumes its input is already synchronous to clk_in.
*/
`timescale 1ns/1ps
`include "pbc_cfg.svh"

module pbc_edge_det (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // level and change pulse
  input wire logic level_in,
  output logic change_out
);

  typedef struct packed {
    logic prev;
    logic chg;
  } pbc_edge_st_t;

  pbc_edge_st_t st_r;
  pbc_edge_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = level_in;
    st_nxt.chg = level_in ^ st_r.prev;
    if (srst_in) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign change_out = st_r.chg;

endmodule

/* pbc_xtal_loss.sv */
/*
  crystal loss detector: after a start, counts multiplier x 4 vco cycles and
  reports loss unless a crystal edge is seen in that window.
  assumes vco and crystal activity arrive as enable pulses on clk_in.
*/
`timescale 1ns/1ps
`include "pbc_cfg.svh"

module pbc_xtal_loss (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // control
  input wire logic start_in,
  input wire logic enable_in,
  input wire logic [3:0] mult_in,
  // activity pulses
  input wire logic vco_tick_in,
  input wire logic xtal_edge_in,
  // result
  output logic lost_out
);

  typedef struct packed {
    pbc_pkg::pbc_xld_state_t st;
    logic [`PBC_XLD_CNT_W-1:0] cnt;
    logic seen;
    logic lost;
  } pbc_xld_st_t;

  pbc_xld_st_t s_r;
  pbc_xld_st_t s_nxt;
  logic [`PBC_XLD_CNT_W-1:0] window;

  // zero multiplier behaves as one
  always_comb begin
    window = {(mult_in == 4'h0 ? 4'h1 : mult_in), 2'b00};
  end

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      pbc_pkg::XLD_IDLE: begin
        if (start_in && enable_in) begin
          s_nxt.st = pbc_pkg::XLD_WAIT;
          s_nxt.cnt = '0;
          s_nxt.seen = 1'b0;
          s_nxt.lost = 1'b1;
        end
      end
      pbc_pkg::XLD_WAIT: begin
        if (xtal_edge_in) begin
          s_nxt.seen = 1'b1;
        end
        if (vco_tick_in) begin
          s_nxt.cnt = s_r.cnt + `PBC_XLD_CNT_W'h1;
          if (s_r.cnt + `PBC_XLD_CNT_W'h1 >= window) begin
            s_nxt.st = pbc_pkg::XLD_DONE;
            s_nxt.lost = ~(s_r.seen | xtal_edge_in);
          end
        end
      end
      pbc_pkg::XLD_DONE: begin
        s_nxt.st = pbc_pkg::XLD_IDLE;
      end
      default: begin
        s_nxt.st = pbc_pkg::XLD_IDLE;
      end
    endcase
    // detector only runs while vco drives the base clock
    if (!enable_in) begin
      s_nxt.st = pbc_pkg::XLD_IDLE;
      s_nxt.lost = 1'b0;
    end
    if (srst_in) begin
      s_nxt = '{st: pbc_pkg::XLD_IDLE, cnt: '0, seen: 1'b0, lost: 1'b0};
    end
  end

  always_ff @(posedge clk_in) begin
    s_r <= s_nxt;
  end

  assign lost_out = s_r.lost;

endmodule

/* pbc_ctrl.sv */
/*
  control and status logic of the clock generator loop: control, bandwidth,
  programming and break registers over apb, lock-change flag and irq, stop
  behaviour and the base clock divide-by-two.
  assumes analog loop supplies lock/acq levels and vco/crystal enable pulses
  on clk_in; stop and break come from the system integration logic.

//Summary of operation
//- auto mode makes track bit read-only status
//- hidden store keeps manual track value
//- reset clears track bit: acquisition
//- write 1 to loss bit, wait Nx4
//- loss detect only with vco selected
//- multiplier 1..15, zero acts as one
//- multiplier resets to six
//- multiplier locked while loop powered
//- vco range locked while loop powered
//- range zero disables loop, blocks select
//- vco range resets to six
//- lock change sets flag; enable gates irq
//- manual mode: no irq, flag reads 0
//- vco selectable while unlocked
//- wait mode keeps generator running
//- stop forces clocks and irq low
//- stop clears vco select bit
//- break with clear-enable keeps clears
//- break without clear-enable protects flag
//- control read clears flag outside break
//- select needs power; power kept while selected
//- manual mode: lock reads 0
*/
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "pbc_cfg.svh"

module pbc_ctrl (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // apb slave
  input wire pbc_pkg::pbc_apb_req_t apb_req_in,
  output pbc_pkg::pbc_apb_rsp_t apb_rsp_out,
  // analog loop status
  input wire logic loop_lock_in,
  input wire logic loop_tracking_in,
  input wire logic vco_tick_in,
  input wire logic xtal_tick_in,
  // system state
  input wire logic stop_in,
  input wire logic wait_in,
  input wire logic break_in,
  // loop control outputs
  output logic loop_enable_out,
  output logic loop_track_out,
  output logic [3:0] feedback_multiplier_out,
  output logic [3:0] vco_range_field_out,
  output logic crystal_clock_out,
  output logic base_clock_out,
  output logic loop_irq_line_out
);

  typedef struct packed {
    logic loop_irq_enable;
    logic loop_change_flag;
    logic loop_power_on;
    logic base_clock_vco_select;
    logic auto_bw;
    logic track_manual;
    logic track_hidden;
    logic [3:0] feedback_multiplier;
    logic [3:0] vco_range_field;
    logic break_flag_clear_enable;
    logic [31:0] prdata;
    logic pready;
    logic irq;
    logic xclk;
    logic bclk;
    logic en;
    logic trk;
  } pbc_state_t;

  pbc_state_t s_r;
  pbc_state_t s_nxt;
  logic lock_chg;
  logic xld_lost;
  logic xld_start;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // setup phase only: one access, answer in the following access cycle
  logic setup_ph;
  logic wr_ph;
  logic [7:0] wd;
  logic lock_vis;
  logic range_zero;
  assign setup_ph = apb_req_in.psel && !apb_req_in.penable;
  assign wr_ph = setup_ph && apb_req_in.pwrite;
  assign wd = apb_req_in.pwdata[7:0];
  assign lock_vis = s_r.auto_bw & loop_lock_in;
  assign range_zero = (s_r.vco_range_field == 4'h0);
  assign xld_start = wr_ph && hit(apb_req_in.paddr, `PBC_OFS_BANDWIDTH) && wd[`PBC_BW_XLOSS];

  pbc_edge_det u_lock_edge (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .level_in(lock_vis),
    .change_out(lock_chg)
  );

  pbc_xtal_loss u_xld (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(xld_start),
    .enable_in(s_r.base_clock_vco_select),
    .mult_in(s_r.feedback_multiplier),
    .vco_tick_in(vco_tick_in),
    .xtal_edge_in(xtal_tick_in),
    .lost_out(xld_lost)
  );

  always_comb begin
    logic [7:0] rd;
    logic flag_clr_ok;
    logic sel_clk;
    rd = 8'h00;
    sel_clk = 1'b0;
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    flag_clr_ok = !break_in || s_r.break_flag_clear_enable;
    // lock change sets the flag; set wins over a read clear below
    if (setup_ph && !apb_req_in.pwrite && hit(apb_req_in.paddr, `PBC_OFS_CONTROL) && flag_clr_ok) begin
      s_nxt.loop_change_flag = 1'b0;
    end
    if (setup_ph) begin
      s_nxt.pready = 1'b1;
      case (apb_req_in.paddr)
        `PBC_OFS_CONTROL: begin
          rd = {s_r.loop_irq_enable & s_r.auto_bw, s_r.loop_change_flag & s_r.auto_bw,
                s_r.loop_power_on, s_r.base_clock_vco_select, `PBC_CTL_UNUSED};
          if (apb_req_in.pwrite) begin
            if (s_r.auto_bw) begin
              s_nxt.loop_irq_enable = wd[`PBC_CTL_IRQ_EN];
            end
            // power cannot drop while selected; select needs power and nonzero range
            s_nxt.loop_power_on = wd[`PBC_CTL_PWR_ON] | s_r.base_clock_vco_select;
            s_nxt.base_clock_vco_select = wd[`PBC_CTL_BCS] & s_r.loop_power_on & ~range_zero;
          end
        end
        `PBC_OFS_BANDWIDTH: begin
          rd = {s_r.auto_bw, lock_vis,
                s_r.auto_bw ? loop_tracking_in : s_r.track_manual,
                xld_lost & s_r.base_clock_vco_select, 4'h0};
          if (apb_req_in.pwrite) begin
            s_nxt.auto_bw = wd[`PBC_BW_AUTO];
            if (!s_r.auto_bw) begin
              s_nxt.track_manual = wd[`PBC_BW_TRACK];
              s_nxt.track_hidden = wd[`PBC_BW_TRACK];
            end
            if (s_r.auto_bw && !wd[`PBC_BW_AUTO]) begin
              s_nxt.track_manual = s_r.track_hidden;
            end
          end
        end
        `PBC_OFS_PROGRAMMING: begin
          rd = {s_r.feedback_multiplier, s_r.vco_range_field};
          if (apb_req_in.pwrite && !s_r.loop_power_on) begin
            s_nxt.feedback_multiplier = wd[`PBC_PG_MUL_HI:`PBC_PG_MUL_LO];
            s_nxt.vco_range_field = wd[`PBC_PG_VRS_HI:`PBC_PG_VRS_LO];
          end
        end
        `PBC_OFS_SYSTEM: begin
          rd = {7'h00, s_r.break_flag_clear_enable};
          if (apb_req_in.pwrite) begin
            s_nxt.break_flag_clear_enable = wd[`PBC_SYS_BREAK_FLAG_CLEAR_ENABLE];
          end
        end
        default: begin
          rd = 8'h00;
        end
      endcase
      s_nxt.prdata = {24'h000000, rd};
    end
    if (s_r.auto_bw && lock_chg) begin
      s_nxt.loop_change_flag = 1'b1;
    end
    if (!s_r.auto_bw) begin
      s_nxt.loop_change_flag = 1'b0;
      s_nxt.loop_irq_enable = 1'b0;
    end
    if (s_nxt.vco_range_field == 4'h0) begin
      s_nxt.base_clock_vco_select = 1'b0;
    end
    // wait mode changes nothing here: the generator keeps running
    if (stop_in) begin
      s_nxt.base_clock_vco_select = 1'b0;
    end
    // clocks: crystal clock toggles on each crystal tick, base clock on each selected tick
    sel_clk = s_r.base_clock_vco_select ? vco_tick_in : xtal_tick_in;
    s_nxt.xclk = xtal_tick_in ? ~s_r.xclk : s_r.xclk;
    s_nxt.bclk = sel_clk ? ~s_r.bclk : s_r.bclk;
    s_nxt.irq = s_r.auto_bw & s_r.loop_irq_enable & s_r.loop_change_flag;
    s_nxt.en = s_r.loop_power_on & ~range_zero;
    s_nxt.trk = s_r.auto_bw ? loop_tracking_in : s_r.track_manual;
    if (stop_in) begin
      s_nxt.xclk = 1'b0;
      s_nxt.bclk = 1'b0;
      s_nxt.irq = 1'b0;
      s_nxt.en = 1'b0;
    end
    if (srst_in) begin
      s_nxt = '0;
      s_nxt.loop_power_on = 1'b1;
      s_nxt.track_manual = 1'b0;
      s_nxt.feedback_multiplier = `PBC_RST_MUL;
      s_nxt.vco_range_field = `PBC_RST_VRS;
    end
  end

  always_ff @(posedge clk_in) begin
    s_r <= s_nxt;
  end

  assign apb_rsp_out = '{prdata: s_r.prdata, pready: s_r.pready, pslverr: 1'b0};
  assign loop_enable_out = s_r.en;
  assign loop_track_out = s_r.trk;
  assign feedback_multiplier_out = s_r.feedback_multiplier;
  assign vco_range_field_out = s_r.vco_range_field;
  assign crystal_clock_out = s_r.xclk;
  assign base_clock_out = s_r.bclk;
  assign loop_irq_line_out = s_r.irq;

endmodule

/* pbc_ctrl_sva.sv */
/*
  checker for pbc_ctrl: bus answer timing, stop, reset values, field locks.
  assumes binding to pbc_ctrl in the bench.
*/
`timescale 1ns/1ps
module pbc_ctrl_sva (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // bus and inputs
  input wire pbc_pkg::pbc_apb_req_t apb_req_in,
  input wire pbc_pkg::pbc_apb_rsp_t apb_rsp_out,
  input wire logic vco_tick_in,
  input wire logic xtal_tick_in,
  input wire logic stop_in,
  // outputs watched
  input wire logic loop_enable_out,
  input wire logic [3:0] feedback_multiplier_out,
  input wire logic [3:0] vco_range_field_out,
  input wire logic crystal_clock_out,
  input wire logic base_clock_out,
  input wire logic loop_irq_line_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence setup_s; apb_req_in.psel && !apb_req_in.penable; endsequence
  sequence stopped_s; stop_in ##1 stop_in; endsequence
  ready_next_a: assert property (setup_s |=> apb_rsp_out.pready) else $error("no ready after setup");
  ready_once_a: assert property (apb_rsp_out.pready |=> !apb_rsp_out.pready) else $error("ready held");
  stop_quiet_a: assert property (stopped_s |-> !crystal_clock_out && !base_clock_out && !loop_irq_line_out)
    else $error("outputs active in stop");
  stop_loop_off_a: assert property (stop_in |=> !loop_enable_out)
    else $error("loop enabled in stop");
  field_reset_a: assert property ($fell(srst_in) |-> feedback_multiplier_out == 4'h6 && vco_range_field_out == 4'h6)
    else $error("field reset value");
  field_lock_a: assert property (loop_enable_out |=> $stable(feedback_multiplier_out) && $stable(vco_range_field_out))
    else $error("field written while loop on");
  range_off_a: assert property ((vco_range_field_out == 4'h0) [*2] |-> !loop_enable_out)
    else $error("loop on with zero range");
  base_step_a: assert property ($changed(base_clock_out) |-> $past(vco_tick_in || xtal_tick_in || stop_in))
    else $error("base clock moved without tick");
  xtal_step_a: assert property ($changed(crystal_clock_out) |-> $past(xtal_tick_in || stop_in))
    else $error("crystal clock moved without tick");
endmodule

/* pbc_loop_model.sv */
/*
  analog loop stand-in: vco tick every second cycle, crystal tick every
  eighth while the crystal is present. assumes one clock with the block.
*/
`timescale 1ns/1ps
module pbc_loop_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // crystal presence
  input wire logic xtal_on_in,
  // activity pulses
  output logic vco_tick_out,
  output logic xtal_tick_out
);
  logic [2:0] cnt_r;
  always_ff @(posedge clk_in) begin
    cnt_r <= srst_in ? 3'h0 : cnt_r + 3'h1;
    vco_tick_out <= !srst_in && cnt_r[0];
    xtal_tick_out <= !srst_in && xtal_on_in && cnt_r == 3'h4;
  end
endmodule

/* test_pbc_ctrl.sv */
/*
  self-checking bench of pbc_ctrl over apb with the loop model.
  assumes the design, package and checker files compiled before it.
*/
`timescale 1ns/1ps
module test_pbc_ctrl;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  pbc_pkg::pbc_apb_req_t req = '0;
  pbc_pkg::pbc_apb_rsp_t rsp;
  logic lock = 1'b0, trk = 1'b0, xon = 1'b1, stp = 1'b0, wt = 1'b0, brk = 1'b0;
  logic vt, xt, en, tr, cx, bc, irq;
  logic [3:0] mul, vrs;
  logic [7:0] rd;
  int mismatches = 0, tests_run = 0;
  always #2 clk_in = ~clk_in;
  pbc_loop_model lm (.clk_in, .srst_in, .xtal_on_in(xon), .vco_tick_out(vt), .xtal_tick_out(xt));
  pbc_ctrl dut (.clk_in, .srst_in, .apb_req_in(req), .apb_rsp_out(rsp), .loop_lock_in(lock),
    .loop_tracking_in(trk), .vco_tick_in(vt), .xtal_tick_in(xt), .stop_in(stp), .wait_in(wt),
    .break_in(brk), .loop_enable_out(en), .loop_track_out(tr), .feedback_multiplier_out(mul),
    .vco_range_field_out(vrs), .crystal_clock_out(cx), .base_clock_out(bc), .loop_irq_line_out(irq));
  task automatic stop_test;
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // one transfer; an idle cycle after it keeps drivers from colliding
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
    rd = rsp.prdata[7:0];
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic t_reset;
    apb(0, 8'h08, 0); chk(rd, 8'h66);
    chk({mul, vrs}, 8'h66);
    apb(0, 8'h04, 0); chk(rd, 8'h00);
  endtask
  task automatic t_prog;
    apb(1, 8'h08, 8'h35); apb(0, 8'h08, 0); chk(rd, 8'h66);
    apb(1, 8'h00, 8'h00); apb(1, 8'h08, 8'h30);
    apb(1, 8'h00, 8'h30); apb(0, 8'h00, 0); chk(rd, 8'h2f);
    chk({7'h0, en}, 8'h00);
    apb(1, 8'h00, 8'h00); apb(1, 8'h08, 8'h66); apb(1, 8'h00, 8'h20);
    chk({mul, vrs}, 8'h66);
  endtask
  task automatic t_track;
    apb(1, 8'h04, 8'h20); apb(0, 8'h04, 0); chk(rd, 8'h20);
    chk({7'h0, tr}, 8'h01);
    apb(1, 8'h04, 8'ha0); apb(0, 8'h04, 0); chk(rd, 8'h80);
    chk({7'h0, tr}, 8'h00);
    apb(1, 8'h04, 8'h00); apb(0, 8'h04, 0); chk(rd, 8'h20);
    apb(1, 8'h04, 8'h00); apb(0, 8'h04, 0); chk(rd, 8'h00);
  endtask
  task automatic t_irq;
    apb(1, 8'h04, 8'h80); apb(1, 8'h00, 8'ha0);
    lock <= 1'b1; cyc(4); chk({7'h0, irq}, 8'h01);
    apb(0, 8'h04, 0); chk(rd, 8'hc0);
    apb(0, 8'h00, 0); chk(rd, 8'hef);
    apb(0, 8'h00, 0); chk(rd, 8'haf);
    chk({7'h0, irq}, 8'h00);
    apb(1, 8'h00, 8'h20); lock <= 1'b0; cyc(4); chk({7'h0, irq}, 8'h00);
    brk <= 1'b1; apb(0, 8'h00, 0); chk(rd, 8'h6f);
    apb(0, 8'h00, 0); chk(rd, 8'h6f);
    apb(1, 8'h0c, 8'h01); apb(0, 8'h00, 0); apb(0, 8'h00, 0); chk(rd, 8'h2f);
    brk <= 1'b0; apb(0, 8'h00, 0); chk(rd, 8'h2f);
    apb(1, 8'h0c, 8'h00); apb(1, 8'h04, 8'h00); lock <= 1'b1; cyc(4);
    apb(0, 8'h00, 0); chk(rd, 8'h2f);
    apb(0, 8'h04, 0); chk(rd, 8'h00);
  endtask
  task automatic t_loss;
    apb(1, 8'h00, 8'h30); apb(0, 8'h00, 0); chk(rd, 8'h3f);
    apb(1, 8'h04, 8'h10); cyc(60); apb(0, 8'h04, 0); chk(rd, 8'h00);
    xon <= 1'b0; apb(1, 8'h04, 8'h10); cyc(60); apb(0, 8'h04, 0); chk(rd, 8'h10);
    apb(1, 8'h00, 8'h10); apb(0, 8'h00, 0); chk(rd, 8'h3f);
  endtask
  task automatic t_power;
    wt <= 1'b1; cyc(8); chk({7'h0, en}, 8'h01);
    wt <= 1'b0; stp <= 1'b1; cyc(4); chk({5'h0, cx, bc, irq}, 8'h00);
    stp <= 1'b0; cyc(2); apb(0, 8'h00, 0); chk(rd, 8'h2f);
    apb(0, 8'h04, 0); chk(rd, 8'h00);
  endtask
  initial begin
    cyc(3);
    srst_in <= 1'b0;
    cyc(1);
    t_reset();
    t_prog();
    t_track();
    t_irq();
    t_loss();
    t_power();
    stop_test();
  end
endmodule
bind pbc_ctrl pbc_ctrl_sva sva_i (.clk_in, .srst_in, .apb_req_in, .apb_rsp_out, .vco_tick_in, .xtal_tick_in,
  .stop_in, .loop_enable_out, .feedback_multiplier_out, .vco_range_field_out, .crystal_clock_out,
  .base_clock_out, .loop_irq_line_out);
